// [design/tpou_pkg.sv]
package tpou_pkg;
   // register indices, address bits 17..2; byte address is index * 4
   localparam logic [15:0] OFF_MODE      = 16'hFFA0;
   localparam logic [15:0] OFF_CONTROL   = 16'hFFA1;
   localparam logic [15:0] OFF_UPPER_EN  = 16'hFFA2;
   localparam logic [15:0] OFF_LOWER_EN  = 16'hFFA3;
   localparam logic [15:0] OFF_UPPER_STG = 16'hFFA4;
   localparam logic [15:0] OFF_LOWER_STG = 16'hFFA5;
   localparam logic [15:0] OFF_G2_STG    = 16'hFFA6;
   localparam logic [15:0] OFF_G0_STG    = 16'hFFA7;
   localparam logic [15:0] OFF_A_DIR     = 16'hFFD1;
   localparam logic [15:0] OFF_A_LATCH   = 16'hFFD3;
   localparam logic [15:0] OFF_B_DIR     = 16'hFFD4;
   localparam logic [15:0] OFF_B_LATCH   = 16'hFFD6;

   // values after reset
   localparam logic [7:0] RST_MODE    = 8'hF0;
   localparam logic [7:0] RST_CONTROL = 8'hFF;
   localparam logic [7:0] RST_ZERO    = 8'h00;

   // reserved bits and write-only registers read as ones
   localparam logic [7:0] RSV_BYTE   = 8'hFF;
   localparam logic [3:0] RSV_NIBBLE = 4'hF;
   localparam logic [7:0] MODE_RSV   = 8'hF0;   // upper mode bits fixed at one

   // field layout of control and mode registers
   localparam int TRIG_SEL_W   = 2;   // trigger channel select per group
   localparam int NOVL_POS     = 0;   // non-overlap bit of group g at NOVL_POS + g
   localparam int GROUP_W      = 4;
   localparam int GROUPS       = 4;
   localparam int CHANNELS     = 4;
   localparam int NO_PIN_BIT   = 14;  // pattern bit with no external pin
endpackage : tpou_pkg

// [design/tpou_core.sv]
`timescale 1ns/100ps
`default_nettype none
module tpou_core #(
   parameter int ADDR_W = 32
) (
   input  wire logic                clock,
   input  wire logic                resetn,
   input  wire logic [ADDR_W-1:0]   address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [3:0]          byteenable,
   input  wire logic [31:0]         writedata,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   input  wire logic [3:0]          compareMatchA,
   input  wire logic [3:0]          compareMatchB,
   output logic      [7:0]          portAPinOut,
   output logic      [7:0]          portAPinOe,
   output logic      [6:0]          portBPinOut,
   output logic      [6:0]          portBPinOe
);
   import tpou_pkg::*;

   logic [7:0]  modeQ, modeD;
   logic [7:0]  controlQ, controlD;
   logic [7:0]  upperEnQ, upperEnD;
   logic [7:0]  lowerEnQ, lowerEnD;
   logic [7:0]  upperStgQ, upperStgD;
   logic [7:0]  lowerStgQ, lowerStgD;
   logic [7:0]  aDirQ, aDirD;
   logic [7:0]  bDirQ, bDirD;
   logic [7:0]  aLatchQ, aLatchD;
   logic [7:0]  bLatchQ, bLatchD;
   logic        ackQ, ackD;
   logic [7:0]  rdataQ, rdataD;
   logic [15:0] regIndex;
   logic [15:0] loadMask;
   logic [15:0] stagedAll;
   logic [15:0] enableAll;
   logic        lowSame;
   logic        upSame;
   logic        wrEn;
   logic [7:0]  wb;

   // word-aligned byte addresses, register index from address bits 17..2
   assign regIndex = address[17:2];

   assign stagedAll = {upperStgQ, lowerStgQ};
   assign enableAll = {upperEnQ, lowerEnQ};

   // pairs share a trigger when their channel selects agree
   assign lowSame = (controlQ[1:0] == controlQ[3:2]);
   assign upSame  = (controlQ[5:4] == controlQ[7:6]);

   // per-group trigger selection and per-bit load decision
   generate
      for (genvar g = 0; g < GROUPS; g++) begin : gGroup
         logic [TRIG_SEL_W-1:0] chanSel;
         logic                  hitA;
         logic                  hitB;
         logic                  novl;
         assign chanSel = controlQ[g*TRIG_SEL_W +: TRIG_SEL_W];
         assign hitA    = compareMatchA[chanSel];
         assign hitB    = compareMatchB[chanSel];
         assign novl    = modeQ[NOVL_POS + g];
         for (genvar b = 0; b < GROUP_W; b++) begin : gBit
            localparam int N = g*GROUP_W + b;
            // non-overlap: falling bits move on A, rising bits wait for B
            assign loadMask[N] = enableAll[N] &
               (novl ? ((hitB & stagedAll[N]) | (hitA & ~stagedAll[N]))
                     : hitB);
         end
      end
   endgenerate

   // bus write strobe: takes effect at the edge where waitrequest is low
   assign wrEn = write & ackQ & byteenable[0];
   assign wb   = writedata[7:0];

   // next values of all registers
   always_comb begin
      modeD     = modeQ;
      controlD  = controlQ;
      upperEnD  = upperEnQ;
      lowerEnD  = lowerEnQ;
      upperStgD = upperStgQ;
      lowerStgD = lowerStgQ;
      aDirD     = aDirQ;
      bDirD     = bDirQ;
      // compare-match transfer of enabled bits
      aLatchD   = (aLatchQ & ~loadMask[7:0]) | (lowerStgQ & loadMask[7:0]);
      bLatchD   = (bLatchQ & ~loadMask[15:8]) | (upperStgQ & loadMask[15:8]);
      ackD      = (read | write) & ~ackQ;
      rdataD    = rdataQ;
      if (wrEn) begin
         case (regIndex)
            OFF_MODE:     modeD    = wb | MODE_RSV;
            OFF_CONTROL:  controlD = wb;
            OFF_UPPER_EN: upperEnD = wb;
            OFF_LOWER_EN: lowerEnD = wb;
            OFF_LOWER_STG: begin
               if (lowSame) begin
                  lowerStgD = wb;
               end else begin
                  lowerStgD[7:4] = wb[7:4];
               end
            end
            OFF_G0_STG: begin
               if (!lowSame) begin
                  lowerStgD[3:0] = wb[3:0];
               end
            end
            OFF_UPPER_STG: begin
               if (upSame) begin
                  upperStgD = wb;
               end else begin
                  upperStgD[7:4] = wb[7:4];
               end
            end
            OFF_G2_STG: begin
               if (!upSame) begin
                  upperStgD[3:0] = wb[3:0];
               end
            end
            OFF_A_DIR:   aDirD = wb;
            OFF_B_DIR:   bDirD = wb;
            // enabled bits belong to the transfer path only
            OFF_A_LATCH: aLatchD = (aLatchD & lowerEnQ) | (wb & ~lowerEnQ);
            OFF_B_LATCH: bLatchD = (bLatchD & upperEnQ) | (wb & ~upperEnQ);
            default: ;
         endcase
      end
      // read data captured in the wait cycle, stands at the answering edge
      if (read & ~ackQ) begin
         case (regIndex)
            OFF_MODE:     rdataD = modeQ;
            OFF_CONTROL:  rdataD = controlQ;
            OFF_UPPER_EN: rdataD = upperEnQ;
            OFF_LOWER_EN: rdataD = lowerEnQ;
            OFF_LOWER_STG: rdataD = lowSame ? lowerStgQ
                                            : {lowerStgQ[7:4], RSV_NIBBLE};
            OFF_G0_STG:   rdataD = lowSame ? RSV_BYTE
                                           : {RSV_NIBBLE, lowerStgQ[3:0]};
            OFF_UPPER_STG: rdataD = upSame ? upperStgQ
                                           : {upperStgQ[7:4], RSV_NIBBLE};
            OFF_G2_STG:   rdataD = upSame ? RSV_BYTE
                                          : {RSV_NIBBLE, upperStgQ[3:0]};
            OFF_A_DIR:    rdataD = RSV_BYTE; // write-only
            OFF_B_DIR:    rdataD = RSV_BYTE;
            OFF_A_LATCH:  rdataD = aLatchQ;
            OFF_B_LATCH:  rdataD = bLatchQ;
            default:      rdataD = RST_ZERO;
         endcase
      end
   end

   // register stage for all state
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         modeQ     <= RST_MODE;
         controlQ  <= RST_CONTROL;
         upperEnQ  <= RST_ZERO;
         lowerEnQ  <= RST_ZERO;
         upperStgQ <= RST_ZERO;
         lowerStgQ <= RST_ZERO;
         aDirQ     <= RST_ZERO;
         bDirQ     <= RST_ZERO;
         aLatchQ   <= RST_ZERO;
         bLatchQ   <= RST_ZERO;
         ackQ      <= 1'b0;
         rdataQ    <= RST_ZERO;
      end else begin
         modeQ     <= modeD;
         controlQ  <= controlD;
         upperEnQ  <= upperEnD;
         lowerEnQ  <= lowerEnD;
         upperStgQ <= upperStgD;
         lowerStgQ <= lowerStgD;
         aDirQ     <= aDirD;
         bDirQ     <= bDirD;
         aLatchQ   <= aLatchD;
         bLatchQ   <= bLatchD;
         ackQ      <= ackD;
         rdataQ    <= rdataD;
      end
   end

   // every access waits exactly one cycle so read data can be registered
   assign waitrequest = (read | write) & ~ackQ;
   assign readdata    = {24'h000000, rdataQ};

   // pins: port A is pattern bits 7..0, direction set by software
   assign portAPinOut = aLatchQ;
   assign portAPinOe  = aDirQ;
   // bit 14 is held internally and read back on the bus, but has no pin
   assign portBPinOut = {bLatchQ[7], bLatchQ[5:0]};
   assign portBPinOe  = {bDirQ[7], bDirQ[5:0]};
endmodule : tpou_core
`default_nettype wire

// [testbench/tpou_checker_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module tpou_checker #(
   parameter int ADDR_W = 32
) (
   input wire logic              clock,
   input wire logic              resetn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [3:0]        byteenable,
   input wire logic [31:0]       writedata,
   input wire logic [31:0]       readdata,
   input wire logic              waitrequest,
   input wire logic [3:0]        compareMatchA,
   input wire logic [3:0]        compareMatchB,
   input wire logic [7:0]        portAPinOut,
   input wire logic [7:0]        portAPinOe,
   input wire logic [6:0]        portBPinOut,
   input wire logic [6:0]        portBPinOe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // bus: one wait cycle, none while idle, byte lane only
   wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
   wait_idle_a: assert property (!(read || write) |-> !waitrequest)
      else $error("wait while idle");
   rd_hold_a: assert property ($changed(readdata) |-> $past(read) && readdata[31:8] == 24'h0)
      else $error("read data moved");
   // pins move only after a match or a write, never by themselves
   a_pin_cause_a: assert property ($changed(portAPinOut) |-> $past(|compareMatchA || |compareMatchB || write))
      else $error("port a moved alone");
   b_pin_cause_a: assert property ($changed(portBPinOut) |-> $past(|compareMatchA || |compareMatchB || write))
      else $error("port b moved alone");
   a_dir_cause_a: assert property ($changed(portAPinOe) |-> $past(write))
      else $error("port a enable moved");
   b_dir_cause_a: assert property ($changed(portBPinOe) |-> $past(write))
      else $error("port b enable moved");
   rst_zero_a: assert property ($rose(resetn) |-> portAPinOut == 8'h00 && portBPinOe == 7'h00)
      else $error("outputs not cleared");
endmodule : tpou_checker
bind tpou_core tpou_checker #(.ADDR_W(ADDR_W)) tpou_checker_i (.clock, .resetn, .address, .read,
   .write, .byteenable, .writedata, .readdata, .waitrequest, .compareMatchA, .compareMatchB,
   .portAPinOut, .portAPinOe, .portBPinOut, .portBPinOe);
`default_nettype wire

// [testbench/tpou_timer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tpou_timer_model (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       fire,
   input  wire logic [1:0] chan,
   input  wire logic       useB,
   output logic      [3:0] compareMatchA,
   output logic      [3:0] compareMatchB
);
   logic [3:0] matchA_d, matchB_d;
   // one pulse per command; a and b never together, the timer inhibits that
   always_comb begin
      matchA_d = (fire && !useB) ? 4'h1 << chan : 4'h0;
      matchB_d = (fire && useB) ? 4'h1 << chan : 4'h0;
   end
   // pulses registered so they start just after an edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         compareMatchA <= 4'h0;
         compareMatchB <= 4'h0;
      end else begin
         compareMatchA <= matchA_d;
         compareMatchB <= matchB_d;
      end
   end
endmodule : tpou_timer_model
`default_nettype wire

// [testbench/test_timed_pattern_output_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module test_timed_pattern_output_unit;
   import tpou_pkg::*;
   logic clock = 1'b0, resetn, read, write, waitrequest, fire, useB;
   logic [31:0] address, writedata, readdata;
   logic [3:0]  byteenable, compareMatchA, compareMatchB;
   logic [7:0]  portAPinOut, portAPinOe;
   logic [6:0]  portBPinOut, portBPinOe;
   logic [1:0]  chan;
   int miscompares = 0, compares = 0;
   always #12.5 clock = ~clock;
   tpou_core tpou_core_i (.clock, .resetn, .address, .read, .write, .byteenable, .writedata,
      .readdata, .waitrequest, .compareMatchA, .compareMatchB, .portAPinOut, .portAPinOe,
      .portBPinOut, .portBPinOe);
   tpou_timer_model tpou_timer_model_i (.clock, .resetn, .fire, .chan, .useB, .compareMatchA,
      .compareMatchB);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one avalon transfer; upper address bits set to show they are ignored
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      address <= {14'h1, idx, 2'h0};
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      // waitrequest and read data are judged at the rising edge itself
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge clock);
      end
      if (n >= 20) begin
         miscompares++;
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // one idle edge so the next call never re-raises a strobe in this step
      @(posedge clock);
   endtask : bus
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(q, 32'(exp));
   endtask : rdc
   // ask the timer for a match, then let the latch settle
   task automatic hit(input logic [1:0] c, input logic b);
      chan <= c;
      useB <= b;
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : hit
   task automatic t_reset;
      logic [15:0] z[6] = '{OFF_UPPER_EN, OFF_LOWER_EN, OFF_UPPER_STG, OFF_LOWER_STG,
                            OFF_A_LATCH, OFF_B_LATCH};
      rdc(OFF_MODE, 8'hF0);
      rdc(OFF_CONTROL, 8'hFF);
      foreach (z[i]) rdc(z[i], 8'h00);
      rdc(OFF_A_DIR, 8'hFF);
      rdc(OFF_G0_STG, 8'hFF);
      rdc(16'hFFB0, 8'h00);
   endtask : t_reset
   task automatic t_shared;
      wr(OFF_A_DIR, 8'hFF);
      wr(OFF_B_DIR, 8'hFF);
      chk(32'(portBPinOe), 32'h7F);
      chk(32'(portAPinOe), 32'hFF);
      wr(OFF_LOWER_EN, 8'hFF);
      wr(OFF_UPPER_EN, 8'hFF);
      wr(OFF_LOWER_STG, 8'hA5);
      wr(OFF_UPPER_STG, 8'h7C);
      hit(2'h3, 1'b1);
      chk(32'(portAPinOut), 32'hA5);
      chk(32'(portBPinOut), 32'h3C);
      wr(OFF_A_LATCH, 8'h00);
      rdc(OFF_A_LATCH, 8'hA5);
   endtask : t_shared
   // each group on its own channel, so staged data splits
   task automatic t_split;
      wr(OFF_CONTROL, 8'hE4);
      wr(OFF_G0_STG, 8'h03);
      rdc(OFF_G0_STG, 8'hF3);
      wr(OFF_LOWER_STG, 8'h60);
      rdc(OFF_LOWER_STG, 8'h6F);
      wr(OFF_G2_STG, 8'h01);
      wr(OFF_UPPER_STG, 8'h80);
      hit(2'h0, 1'b1);
      chk(32'(portAPinOut), 32'hA3);
      hit(2'h1, 1'b1);
      chk(32'(portAPinOut), 32'h63);
      hit(2'h2, 1'b1);
      chk(32'(portBPinOut), 32'h31);
      hit(2'h3, 1'b1);
      chk(32'(portBPinOut), 32'h41);
   endtask : t_split
   task automatic t_mask;
      wr(OFF_LOWER_EN, 8'h0F);
      wr(OFF_A_LATCH, 8'hFF);
      chk(32'(portAPinOut), 32'hF3);
      wr(OFF_LOWER_STG, 8'h0F);
      hit(2'h1, 1'b1);
      chk(32'(portAPinOut), 32'hF3);
   endtask : t_mask
   // zeros leave on match a, ones on match b
   task automatic t_novl;
      wr(OFF_MODE, 8'h01);
      rdc(OFF_MODE, 8'hF1);
      wr(OFF_G0_STG, 8'h0C);
      hit(2'h0, 1'b0);
      chk(32'(portAPinOut), 32'hF0);
      hit(2'h0, 1'b1);
      chk(32'(portAPinOut), 32'hFC);
   endtask : t_novl
   task automatic print_verdict;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      {resetn, read, write, fire, useB, chan, address, writedata} = '0;
      byteenable = 4'hF;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_reset;
      t_shared;
      t_split;
      t_mask;
      t_novl;
      print_verdict;
   end
   // hang guard, far beyond the roughly 150 cycles the tests need
   initial begin
      repeat (3000) @(posedge clock);
      miscompares++;
      print_verdict;
   end
endmodule : test_timed_pattern_output_unit
`default_nettype wire
